// ---- pkg/ufer_regs.svh ----
// Purpose: Constants for the USB function error and reset-state block.
// Assumes: Byte-wide registers, one clock, active-low asynchronous reset.
// Notes: Reset values and field positions are kept here as macros.
`ifndef UFER_REGS_SVH
`define UFER_REGS_SVH
// Value taken by cleared control and status registers.
`define UFER_CLR_VAL 8'h00
// Value taken by the interrupt-clear registers after a CPU reset.
`define UFER_ICLR_RST 8'hff
// Bit position of the configured flag in the mode status register.
`define UFER_CONFIGURED_FLAG_BIT 2
// Number of endpoint halt flags (endpoints 0, 1, 2 and 7).
`define UFER_NUM_HALT 4
// Halt flag index that stands for endpoint 7.
`define UFER_HALT_EP7 2'h3
// Depth and pointer width of the endpoint receive buffer.
`define UFER_BUF_DEPTH 64
`define UFER_PTR_W 7
// Descriptor store size in bytes.
`define UFER_DSC_DEPTH 256
`endif

// ---- pkg/ufer_pkg.sv ----
// Purpose: Types for the USB function error and reset-state block.
// Assumes: Used together with ufer_regs.svh.
// Notes: Holds only types; numbers live in the header.
package ufer_pkg;
    // Transfer stage of the current endpoint-zero transaction.
    typedef enum logic [1:0] {
        UFER_STG_SETUP = 2'h0,
        UFER_STG_DATA = 2'h1,
        UFER_STG_STATUS = 2'h3
    } ufer_stage_type;
    // Handshake chosen for a received data packet.
    typedef enum logic [1:0] {
        UFER_HS_NONE = 2'h0,
        UFER_HS_ACK = 2'h1,
        UFER_HS_STALL = 2'h3
    } ufer_hs_type;
    // Transaction state, one bit changing per step from IDLE to DATA to HS; HS back to IDLE changes both.
    typedef enum logic [1:0] {
        UFER_ST_IDLE = 2'h0,
        UFER_ST_DATA = 2'h1,
        UFER_ST_HS = 2'h3
    } ufer_state_type;
endpackage : ufer_pkg

// ---- hw/ufer_dsc_mem.sv ----
// Purpose: Descriptor store memory with registered read data.
// Assumes: One write and one read port on the core clock.
// Notes: Contents are never cleared by any reset.
`timescale 1ns/1ps
`include "ufer_regs.svh"
module ufer_dsc_mem
    import ufer_pkg::*;
(
    // Clock.
    input wire logic core_clk_i,
    // Write port.
    input wire logic wr_en_i,
    input wire logic [7:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    // Read port.
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    // Storage array; no reset so contents survive both resets.
    logic [7:0] mem_r [`UFER_DSC_DEPTH];

    // Write and registered read, no reset on purpose.
    always_ff @(posedge core_clk_i)
    begin
        if (wr_en_i)
        begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule : ufer_dsc_mem

// ---- hw/ufer_core.sv ----
// Purpose: Error response and reset-state logic of a USB function.
// Assumes: Packet decode is done upstream and presented as one-cycle pulses.
// Notes: Handshake answer is a one-cycle pulse one cycle after packet end.
`timescale 1ns/1ps
`include "ufer_regs.svh"
// Functional notes
// R1 - Bad or unsupported token gets no response.
// R2 - Bad OUT data ignored; toggle mismatch ACKed, discarded.
// R3 - SETUP overrun: no handshake, discard data.
// R4 - Data-stage overrun: no handshake, stall request, discard.
// R5 - Retry after overrun answered with STALL.
// R6 - Status overrun: short ACK, else stall request.
// R7 - Bulk overrun: no handshake, set endpoint halt.
// R8 - Failed IN handshake keeps data for resend.
// R9 - Data-to-status OUT counts as good reception.
// R10 - Endpoint validity follows selected alternate setting.
// R11 - CPU reset clears, interrupt clear registers to ones; bus reset clears chosen registers.
// R12 - Bus reset clears only configured flag bit.
// R13 - Reset clears buffer pointers and byte counter; the count clears on CPU reset, bus reset keeps it.
// R14 - Descriptor stores kept; writes need NAK-all.
// R15 - Firmware lays endpoint descriptors as seven bytes.
// R16 - Firmware lays interface descriptors as nine bytes.
module ufer_core
    import ufer_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic bus_reset_i,
    // Token decode from the serial engine.
    input wire logic tok_valid_i,
    input wire logic [3:0] tok_ep_i,
    input wire logic tok_dir_in_i,
    input wire logic tok_err_i,
    // Endpoint validity tables per alternate setting and one direction table, indexed by endpoint.
    input wire logic [15:0] ep_valid_alt0_i,
    input wire logic [15:0] ep_valid_alt1_i,
    input wire logic [15:0] ep_dir_in_i,
    // Data packet status.
    input wire logic data_done_i,
    input wire logic data_err_i,
    input wire logic data_crc_err_i,
    input wire logic data_toggle_err_i,
    input wire logic data_overrun_i,
    input wire logic data_short_i,
    input wire logic stage_is_ctrl_i,
    input wire logic [1:0] stage_i,
    input wire logic ep_is_bulk_i,
    input wire logic [1:0] halt_idx_i,
    input wire logic stage_change_i,
    input wire logic rx_byte_i,
    // IN handshake status.
    input wire logic in_hs_done_i,
    input wire logic in_hs_ack_i,
    // Firmware controls.
    input wire logic ep0_nak_all_i,
    input wire logic fifo_clear_i,
    input wire logic stall_clear_i,
    input wire logic dsc_wr_i,
    input wire logic [7:0] dsc_addr_i,
    input wire logic [7:0] dsc_data_i,
    input wire logic alt_set_wr_i,
    input wire logic alt_set_i,
    input wire logic configured_flag_set_i,
    // Answers to the bus side.
    output logic hs_valid_o,
    output logic [1:0] hs_code_o,
    output logic data_keep_o,
    output logic data_discard_o,
    // Status to firmware.
    output logic ep0_stall_request_o,
    output logic [3:0] endpoint_halt_flag_o,
    output logic [7:0] mode_status_reg_o,
    output logic [7:0] alt_setting_status_reg_o,
    output logic [7:0] interrupt_clear_regs_o,
    output logic [6:0] rx_count_o,
    output logic [7:0] dsc_rd_data_o
);
    // Block state in one record, except the descriptor store and its read data register.
    typedef struct packed {
        ufer_state_type st;
        logic [1:0] hs;
        logic hs_v;
        logic keep;
        logic disc;
        logic stall_req;
        logic retry_stall;
        logic [3:0] halt;
        logic [7:0] mode;
        logic [7:0] alt;
        logic [7:0] iclr;
        logic [6:0] cnt;
    } ufer_state_rec_type;

    ufer_state_rec_type s_r;
    ufer_state_rec_type s_nxt;
    logic [7:0] dsc_q;

    // Looks up endpoint validity for the current alternate setting.
    function automatic logic ep_ok(input logic [3:0] ep, input logic alt,
        input logic [15:0] v0, input logic [15:0] v1);
        ep_ok = alt ? v1[ep] : v0[ep];
    endfunction : ep_ok

    // Descriptor store; writes gated by the NAK-all flag.
    // R14 NAK-all write gate
    ufer_dsc_mem u_dsc
    (
        .core_clk_i(core_clk_i),
        .wr_en_i(dsc_wr_i & ep0_nak_all_i),
        .wr_addr_i(dsc_addr_i),
        .wr_data_i(dsc_data_i),
        .rd_addr_i(dsc_addr_i),
        .rd_data_o(dsc_q)
    );

    // Next-state logic for responses and flags.
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.hs_v = 1'b0;
        s_nxt.disc = 1'b0;
        // Stall requests clear by firmware; a new event below wins.
        if (stall_clear_i)
        begin
            s_nxt.stall_req = 1'b0;
            s_nxt.retry_stall = 1'b0;
        end
        if (alt_set_wr_i)
        begin
            s_nxt.alt = {7'h00, alt_set_i};
        end
        if (configured_flag_set_i)
        begin
            s_nxt.mode[`UFER_CONFIGURED_FLAG_BIT] = 1'b1;
        end
        // Byte counter advances per received byte.
        if (rx_byte_i && s_r.cnt != 7'h7f)
        begin
            s_nxt.cnt = s_r.cnt + 7'h01;
        end
        unique case (s_r.st)
            UFER_ST_IDLE:
            begin
                // R1 token screening
                // R10 alt-setting lookup
                if (tok_valid_i && !tok_err_i &&
                    ep_ok(tok_ep_i, s_r.alt[0], ep_valid_alt0_i,
                          ep_valid_alt1_i) &&
                    ep_dir_in_i[tok_ep_i] == tok_dir_in_i)
                begin
                    s_nxt.st = UFER_ST_DATA;
                end
            end
            UFER_ST_DATA:
            begin
                if (in_hs_done_i)
                begin
                    // R8 hold on failure
                    s_nxt.keep = !in_hs_ack_i;
                    s_nxt.st = UFER_ST_IDLE;
                end
                else if (data_done_i)
                begin
                    s_nxt.st = UFER_ST_HS;
                    s_nxt.hs = UFER_HS_NONE;
                    s_nxt.hs_v = 1'b0;
                    // R5 stall the retry
                    if ((s_r.retry_stall && stage_is_ctrl_i) ||
                        (!stage_is_ctrl_i && ep_is_bulk_i &&
                         s_r.halt[halt_idx_i]))
                    begin
                        // Halted bulk endpoints stall their retries too.
                        s_nxt.hs = UFER_HS_STALL;
                        s_nxt.hs_v = 1'b1;
                    end
                    else if (data_err_i)
                    begin
                        // R2 silent on PID faults
                        s_nxt.hs_v = 1'b0;
                    end
                    else if (data_crc_err_i)
                    begin
                        // R2 silent and discard
                        s_nxt.disc = 1'b1;
                    end
                    else if (stage_change_i)
                    begin
                        // R9 accept stage change
                        s_nxt.hs = UFER_HS_ACK;
                        s_nxt.hs_v = 1'b1;
                    end
                    else if (data_toggle_err_i)
                    begin
                        // R2 ACK and discard
                        s_nxt.hs = UFER_HS_ACK;
                        s_nxt.hs_v = 1'b1;
                        s_nxt.disc = 1'b1;
                    end
                    else if (data_overrun_i)
                    begin
                        s_nxt.disc = 1'b1;
                        if (!stage_is_ctrl_i)
                        begin
                            // R7 bulk halt
                            if (ep_is_bulk_i)
                            begin
                                s_nxt.halt[halt_idx_i] = 1'b1;
                            end
                        end
                        else if (stage_i == UFER_STG_DATA)
                        begin
                            // R4 data stage stall
                            s_nxt.stall_req = 1'b1;
                            s_nxt.retry_stall = 1'b1;
                        end
                        else if (stage_i == UFER_STG_STATUS &&
                                 data_short_i)
                        begin
                            // R6 short packet ACK
                            s_nxt.hs = UFER_HS_ACK;
                            s_nxt.hs_v = 1'b1;
                        end
                        else if (stage_i == UFER_STG_STATUS)
                        begin
                            // R6 long packet stall
                            s_nxt.stall_req = 1'b1;
                            s_nxt.retry_stall = 1'b1;
                        end
                        // R3 setup overrun silent, discard only.
                    end
                    else
                    begin
                        s_nxt.hs = UFER_HS_ACK;
                        s_nxt.hs_v = 1'b1;
                    end
                end
            end
            UFER_ST_HS:
            begin
                s_nxt.st = UFER_ST_IDLE;
            end
            default:
            begin
                s_nxt.st = UFER_ST_IDLE;
            end
        endcase
        // R13 buffer pointer clear
        if (fifo_clear_i || s_nxt.disc)
        begin
            s_nxt.cnt = 7'h00;
        end
        // R11 bus reset clears
        if (bus_reset_i)
        begin
            s_nxt.st = UFER_ST_IDLE;
            s_nxt.stall_req = 1'b0;
            s_nxt.retry_stall = 1'b0;
            s_nxt.halt = '0;
            s_nxt.alt = `UFER_CLR_VAL;
            s_nxt.hs_v = 1'b0;
            // R12 configured flag only
            s_nxt.mode[`UFER_CONFIGURED_FLAG_BIT] = 1'b0;
        end
    end

    // State register; CPU reset puts defined values everywhere.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s_r <= '0;
            // R11 interrupt clear to ones
            s_r.iclr <= `UFER_ICLR_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs are registered fields of the state record, plus descriptor read data registered again here.
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            dsc_rd_data_o <= 8'h00;
        end
        else
        begin
            dsc_rd_data_o <= dsc_q;
        end
    end
    assign hs_valid_o = s_r.hs_v;
    assign hs_code_o = s_r.hs;
    assign data_keep_o = s_r.keep;
    assign data_discard_o = s_r.disc;
    assign ep0_stall_request_o = s_r.stall_req;
    assign endpoint_halt_flag_o = s_r.halt;
    assign mode_status_reg_o = s_r.mode;
    assign alt_setting_status_reg_o = s_r.alt;
    assign interrupt_clear_regs_o = s_r.iclr;
    assign rx_count_o = s_r.cnt;

    // R5 retry stall
    AST_RETRY_STALL: assert property (@(posedge core_clk_i) // R5
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_DATA && data_done_i && !in_hs_done_i &&
         s_r.retry_stall && stage_is_ctrl_i && !bus_reset_i)
        |=> (hs_valid_o && hs_code_o == UFER_HS_STALL))
        else $error("retry after overrun not stalled");
    // R12 configured_flag cleared
    AST_BUS_RST_CONFIGURED_FLAG: assert property (@(posedge core_clk_i) // R12
        disable iff (!resetn_i)
        bus_reset_i |=> !mode_status_reg_o[`UFER_CONFIGURED_FLAG_BIT] &&
        mode_status_reg_o[7:3] == $past(mode_status_reg_o[7:3]))
        else $error("bus reset handling of mode status wrong");
    // R11 bus reset clears
    AST_BUS_RST_CLR: assert property (@(posedge core_clk_i) // R11
        disable iff (!resetn_i)
        bus_reset_i |=> alt_setting_status_reg_o == 8'h00 &&
        endpoint_halt_flag_o == 4'h0 && !ep0_stall_request_o)
        else $error("bus reset did not clear registers");
    // R1 bad token
    AST_BAD_TOKEN: assert property (@(posedge core_clk_i) // R1
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_IDLE && tok_valid_i && tok_err_i)
        |=> s_r.st == UFER_ST_IDLE)
        else $error("erroneous token accepted");
    // R2 toggle ack discard
    AST_TOGGLE: assert property (@(posedge core_clk_i) // R2
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_DATA && data_done_i && !in_hs_done_i &&
         !s_r.retry_stall && !data_err_i && !data_crc_err_i &&
         !stage_change_i && data_toggle_err_i && !bus_reset_i &&
         !(!stage_is_ctrl_i && ep_is_bulk_i && s_r.halt[halt_idx_i]))
        |=> hs_valid_o && hs_code_o == UFER_HS_ACK && data_discard_o)
        else $error("toggle mismatch not acked and discarded");
    // R4 data stage stall
    AST_DATA_OVR: assert property (@(posedge core_clk_i) // R4
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_DATA && data_done_i && !in_hs_done_i &&
         !s_r.retry_stall && !data_err_i && !data_crc_err_i &&
         !stage_change_i && !data_toggle_err_i && data_overrun_i &&
         stage_is_ctrl_i && stage_i == UFER_STG_DATA && !bus_reset_i)
        |=> !hs_valid_o && ep0_stall_request_o)
        else $error("data stage overrun not stalled");
    // R8 keep unacked
    AST_IN_KEEP: assert property (@(posedge core_clk_i) // R8
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_DATA && in_hs_done_i && !in_hs_ack_i &&
         !bus_reset_i) |=> data_keep_o)
        else $error("unacked IN data not kept");
    // R13 counter clear
    AST_FIFO_CLR: assert property (@(posedge core_clk_i) // R13
        disable iff (!resetn_i)
        fifo_clear_i |=> rx_count_o == 7'h00)
        else $error("buffer clear left count");
    // R5 halted bulk retry
    AST_BULK_RETRY: assert property (@(posedge core_clk_i) // R5
        disable iff (!resetn_i)
        (s_r.st == UFER_ST_DATA && data_done_i && !in_hs_done_i &&
         !stage_is_ctrl_i && ep_is_bulk_i && s_r.halt[halt_idx_i] &&
         !bus_reset_i) |=> hs_valid_o && hs_code_o == UFER_HS_STALL)
        else $error("retry to halted bulk endpoint not stalled");
endmodule : ufer_core

// ---- verification/ufer_host_model.sv ----
// Purpose: Host-side packet event source for the error and reset-state core.
// Assumes: Each event is a one-cycle pulse launched just after a rising edge.
// Notes: Released qualifiers are flipped, so stale values are never trusted.
`timescale 1ns/1ps
module ufer_host_model (
    // Clock.
    input wire logic core_clk_i,
    // Token events.
    output logic tok_valid_o,
    output logic [3:0] tok_ep_o,
    output logic tok_dir_in_o,
    output logic tok_err_o,
    // Data packet events: stage change, short, overrun, toggle, crc, error.
    output logic data_done_o,
    output logic [5:0] data_flags_o,
    output logic rx_byte_o,
    // IN handshake events.
    output logic in_hs_done_o,
    output logic in_hs_ack_o
);
    // Quiet bus at time zero.
    initial
    begin
        {tok_valid_o, tok_ep_o, tok_dir_in_o, tok_err_o} = 7'h00;
        {data_done_o, data_flags_o, rx_byte_o} = 8'h00;
        {in_hs_done_o, in_hs_ack_o} = 2'h0;
    end

    // Token held over one sampling edge, then its fields are inverted.
    task automatic send_token(input logic [3:0] ep, input logic din,
        input logic err);
        @(posedge core_clk_i);
        #1;
        {tok_valid_o, tok_ep_o, tok_dir_in_o, tok_err_o} = {1'b1, ep, din, err};
        @(posedge core_clk_i);
        #1;
        {tok_valid_o, tok_ep_o, tok_dir_in_o, tok_err_o} = {1'b0, ~ep, ~din, ~err};
    endtask : send_token

    // End of a data packet with its status flags.
    task automatic send_data(input logic [5:0] f);
        @(posedge core_clk_i);
        #1;
        {data_done_o, data_flags_o} = {1'b1, f};
        @(posedge core_clk_i);
        #1;
        {data_done_o, data_flags_o} = {1'b0, ~f};
    endtask : send_data

    // End of the handshake phase of an IN transaction.
    task automatic send_in_hs(input logic ack);
        @(posedge core_clk_i);
        #1;
        {in_hs_done_o, in_hs_ack_o} = {1'b1, ack};
        @(posedge core_clk_i);
        #1;
        {in_hs_done_o, in_hs_ack_o} = {1'b0, ~ack};
    endtask : send_in_hs

    // A burst of received bytes, one per cycle.
    task automatic send_bytes(input int n);
        @(posedge core_clk_i);
        #1;
        rx_byte_o = 1'b1;
        repeat (n) @(posedge core_clk_i);
        #1;
        rx_byte_o = 1'b0;
    endtask : send_bytes
endmodule : ufer_host_model

// ---- verification/ufer_core_tb_top.sv ----
// Purpose: Self-checking bench for the error and reset-state core.
// Assumes: The host model makes packet events; the bench plays firmware.
// Notes: Answers are watched over a four-cycle window after each OUT data packet.
`timescale 1ns/1ps
`include "ufer_regs.svh"
module ufer_core_tb_top
    import ufer_pkg::*;
;
    // Firmware-side controls and packet context.
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic bus_reset_i = 1'b0;
    logic stage_is_ctrl_i = 1'b1;
    logic [1:0] stage_i = 2'h0;
    logic ep_is_bulk_i = 1'b0;
    logic [1:0] halt_idx_i = 2'h0;
    logic ep0_nak_all_i = 1'b0;
    logic fifo_clear_i = 1'b0;
    logic stall_clear_i = 1'b0;
    logic dsc_wr_i = 1'b0;
    logic [7:0] dsc_addr_i = 8'h00;
    logic [7:0] dsc_data_i = 8'h00;
    logic alt_set_wr_i = 1'b0;
    logic alt_set_i = 1'b0;
    logic configured_flag_set_i = 1'b0;
    // Host events.
    logic tok_v, tok_din, tok_e, d_done, rx_b, hs_done, hs_ack;
    logic [3:0] tok_ep;
    logic [5:0] df;
    // Design answers.
    logic hs_valid_o, data_keep_o, data_discard_o, ep0_stall_request_o;
    logic [1:0] hs_code_o;
    logic [3:0] endpoint_halt_flag_o;
    logic [7:0] mode_status_reg_o, alt_setting_status_reg_o;
    logic [7:0] interrupt_clear_regs_o, dsc_rd_data_o;
    logic [6:0] rx_count_o;
    // Bookkeeping.
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    int i;
    // Tokens refused: crc error, unsupported endpoint, wrong direction.
    logic [5:0] bt [3] = '{6'h10, 6'h03, 6'h01};
    // Data faults: none, timeout, crc, toggle mismatch.
    logic [5:0] ef [4] = '{6'h00, 6'h01, 6'h02, 6'h04};
    logic [1:0] eh [4] = '{UFER_HS_ACK, UFER_HS_NONE, UFER_HS_NONE, UFER_HS_ACK};
    logic [1:0] ed [4] = '{2'h0, 2'h0, 2'h1, 2'h1};
    // Endpoint descriptor, interface descriptor, then one spare byte.
    logic [7:0] dsc [17] = '{8'h07, 8'h05, 8'h02, 8'h02, 8'h40, 8'h00,
        8'h00, 8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'h00,
        8'h00, 8'ha5};

    // Endpoints 0, 1, 2 and 7 always exist; endpoint 5 only in alt 1.
    ufer_core i_ufer_core (.core_clk_i, .resetn_i, .bus_reset_i,
        .tok_valid_i(tok_v), .tok_ep_i(tok_ep), .tok_dir_in_i(tok_din),
        .tok_err_i(tok_e), .ep_valid_alt0_i(16'h0087),
        .ep_valid_alt1_i(16'h00a7), .ep_dir_in_i(16'h0002),
        .data_done_i(d_done), .data_err_i(df[0]), .data_crc_err_i(df[1]),
        .data_toggle_err_i(df[2]), .data_overrun_i(df[3]),
        .data_short_i(df[4]), .stage_change_i(df[5]), .stage_is_ctrl_i,
        .stage_i, .ep_is_bulk_i, .halt_idx_i, .rx_byte_i(rx_b),
        .in_hs_done_i(hs_done), .in_hs_ack_i(hs_ack), .ep0_nak_all_i,
        .fifo_clear_i, .stall_clear_i, .dsc_wr_i, .dsc_addr_i, .dsc_data_i,
        .alt_set_wr_i, .alt_set_i, .configured_flag_set_i, .hs_valid_o, .hs_code_o,
        .data_keep_o, .data_discard_o, .ep0_stall_request_o,
        .endpoint_halt_flag_o, .mode_status_reg_o, .alt_setting_status_reg_o,
        .interrupt_clear_regs_o, .rx_count_o, .dsc_rd_data_o);

    ufer_host_model i_ufer_host_model (.core_clk_i, .tok_valid_o(tok_v),
        .tok_ep_o(tok_ep), .tok_dir_in_o(tok_din), .tok_err_o(tok_e),
        .data_done_o(d_done), .data_flags_o(df), .rx_byte_o(rx_b),
        .in_hs_done_o(hs_done), .in_hs_ack_o(hs_ack));

    // 250 MHz core clock.
    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    // Hang guard; the whole sequence needs well under a thousand cycles.
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic done(input string s);
        $display("test done: %s", s);
    endtask : done

    task automatic final_report();
        $display("compares=%0d mismatches=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // OUT transaction; tk is {dir_in, err, ep}; disc 2 means not judged.
    task automatic out_xfer(input logic [5:0] tk, input logic [5:0] f,
        input logic [1:0] hs, input logic [1:0] disc);
        logic seen;
        logic [1:0] code;
        logic dsd;
        seen = 1'b0;
        code = UFER_HS_NONE;
        dsd = 1'b0;
        i_ufer_host_model.send_token(tk[3:0], tk[5], tk[4]);
        i_ufer_host_model.send_data(f);
        // A pulse stands one cycle, so every cycle of the window is looked at.
        repeat (4)
        begin
            if (hs_valid_o === 1'b1)
            begin
                seen = 1'b1;
                code = hs_code_o;
            end
            if (data_discard_o === 1'b1)
                dsd = 1'b1;
            tick(1);
        end
        check(code, hs);
        if (disc != 2'h2)
            check(dsd, disc[0]);
    endtask : out_xfer

    // IN transaction with the given handshake outcome.
    task automatic in_xfer(input logic ack);
        i_ufer_host_model.send_token(4'h1, 1'b1, 1'b0);
        i_ufer_host_model.send_in_hs(ack);
        tick(2);
        check(data_keep_o, ack ? 8'h00 : 8'h01);
    endtask : in_xfer

    task automatic clear_stall();
        stall_clear_i = 1'b1;
        tick(1);
        stall_clear_i = 1'b0;
        tick(1);
        check(ep0_stall_request_o, 8'h00);
    endtask : clear_stall

    initial
    begin
        tick(16);
        resetn_i = 1'b1;
        tick(1);
        check(interrupt_clear_regs_o, `UFER_ICLR_RST);
        check(mode_status_reg_o, `UFER_CLR_VAL);
        check(alt_setting_status_reg_o, `UFER_CLR_VAL);
        check({ep0_stall_request_o, endpoint_halt_flag_o}, 8'h00);
        check(rx_count_o, 8'h00);
        done("reset values");
        // store written under NAK-all in descriptor layout
        ep0_nak_all_i = 1'b1;
        tick(1);
        dsc_wr_i = 1'b1;
        for (i = 0; i < 17; i++)
        begin
            dsc_addr_i = i[7:0];
            dsc_data_i = dsc[i];
            tick(1);
        end
        ep0_nak_all_i = 1'b0;
        dsc_data_i = 8'h5a;
        tick(1);
        dsc_wr_i = 1'b0;
        for (i = 0; i < 3; i++)
            out_xfer(bt[i], 6'h00, UFER_HS_NONE, 2'h0);
        out_xfer(6'h00, 6'h08, UFER_HS_NONE, 2'h1);
        check(ep0_stall_request_o, 8'h00);
        stage_i = 2'h1;
        for (i = 0; i < 4; i++)
            out_xfer(6'h00, ef[i], eh[i], ed[i]);
        out_xfer(6'h00, 6'h08, UFER_HS_NONE, 2'h1);
        check(ep0_stall_request_o, 8'h01);
        out_xfer(6'h00, 6'h00, UFER_HS_STALL, 2'h2);
        clear_stall();
        done("control setup and data stages");
        stage_i = 2'h3;
        out_xfer(6'h00, 6'h18, UFER_HS_ACK, 2'h1);
        check(ep0_stall_request_o, 8'h00);
        out_xfer(6'h00, 6'h08, UFER_HS_NONE, 2'h1);
        check(ep0_stall_request_o, 8'h01);
        clear_stall();
        out_xfer(6'h00, 6'h20, UFER_HS_ACK, 2'h0);
        done("control status stage");
        {stage_is_ctrl_i, ep_is_bulk_i, halt_idx_i} = 4'h7;
        out_xfer(6'h02, 6'h08, UFER_HS_NONE, 2'h2);
        check(endpoint_halt_flag_o, 8'h08);
        halt_idx_i = 2'h1;
        out_xfer(6'h02, 6'h08, UFER_HS_NONE, 2'h2);
        check(endpoint_halt_flag_o, 8'h0a);
        out_xfer(6'h02, 6'h00, UFER_HS_STALL, 2'h2);
        {ep_is_bulk_i, halt_idx_i} = 3'h0;
        out_xfer(6'h05, 6'h00, UFER_HS_NONE, 2'h0);
        {alt_set_wr_i, alt_set_i} = 2'h3;
        tick(1);
        alt_set_wr_i = 1'b0;
        out_xfer(6'h05, 6'h00, UFER_HS_ACK, 2'h0);
        in_xfer(1'b0);
        in_xfer(1'b1);
        done("bulk, alternate setting and IN");
        {stage_is_ctrl_i, stage_i, configured_flag_set_i} = 4'hb;
        tick(1);
        configured_flag_set_i = 1'b0;
        tick(1);
        check(mode_status_reg_o, 8'h01 << `UFER_CONFIGURED_FLAG_BIT);
        out_xfer(6'h00, 6'h08, UFER_HS_NONE, 2'h1);
        check(ep0_stall_request_o, 8'h01);
        i_ufer_host_model.send_bytes(5);
        bus_reset_i = 1'b1;
        tick(1);
        bus_reset_i = 1'b0;
        tick(1);
        check(mode_status_reg_o, `UFER_CLR_VAL);
        check(alt_setting_status_reg_o, `UFER_CLR_VAL);
        check({ep0_stall_request_o, endpoint_halt_flag_o}, 8'h00);
        check(interrupt_clear_regs_o, `UFER_ICLR_RST);
        check(rx_count_o, 8'h05);
        out_xfer(6'h05, 6'h00, UFER_HS_NONE, 2'h0);
        done("bus reset");
        fifo_clear_i = 1'b1;
        tick(1);
        fifo_clear_i = 1'b0;
        tick(1);
        check(rx_count_o, 8'h00);
        i_ufer_host_model.send_bytes(3);
        tick(1);
        check(rx_count_o, 8'h03);
        resetn_i = 1'b0;
        tick(1);
        resetn_i = 1'b1;
        tick(1);
        check(rx_count_o, 8'h00);
        // Store survives both resets; read data lands two cycles on.
        for (i = 0; i < 17; i++)
        begin
            dsc_addr_i = i[7:0];
            tick(2);
            check(dsc_rd_data_o, dsc[i]);
        end
        done("buffer and descriptor store");
        final_report();
    end
endmodule : ufer_core_tb_top
